// *** design/stmc_pkg.sv ***
// Purpose: shared constants and types for the standard timer core
// Assumes: byte-wide register port, one clock domain
// Notes:   register offsets are local choices
package stmc_pkg;
  localparam int         ADDR_W      = 3;
  localparam logic [2:0] OFS_CTRL0   = 3'h0;
  localparam logic [2:0] OFS_CTRL1   = 3'h1;
  localparam logic [2:0] OFS_CNT_LO  = 3'h2;
  localparam logic [2:0] OFS_CNT_HI  = 3'h3;
  localparam logic [2:0] OFS_CMPA_LO = 3'h4;
  localparam logic [2:0] OFS_CMPA_HI = 3'h5;
  localparam logic [2:0] OFS_PERIOD  = 3'h6;
  localparam logic [7:0] CTRL0_MASK  = 8'hf8;
  localparam logic [7:0] RST_BYTE    = 8'h00;
  localparam logic [15:0] RST_WORD   = 16'h0000;
  localparam logic [5:0] RST_PRE     = 6'h00;
  localparam logic [2:0] CKS_SYS_D4  = 3'h0;
  localparam logic [2:0] CKS_SYS     = 3'h1;
  localparam logic [2:0] CKS_HI_D16  = 3'h2;
  localparam logic [2:0] CKS_HI_D64  = 3'h3;
  localparam logic [2:0] CKS_SUB0    = 3'h4;
  localparam logic [2:0] CKS_SUB1    = 3'h5;
  localparam logic [2:0] CKS_EXT_R   = 3'h6;
  localparam logic [2:0] CKS_EXT_F   = 3'h7;
  localparam logic [1:0] PF_00       = 2'h0;
  localparam logic [1:0] PF_01       = 2'h1;
  localparam logic [1:0] PF_10       = 2'h2;
  localparam logic [1:0] PF_11       = 2'h3;
  localparam logic [7:0] PERIOD_OVF  = 8'h00;
  localparam logic [15:0] CNT_MAX    = 16'hffff;
  localparam logic [15:0] CNT_ONE    = 16'h0001;
  localparam logic [1:0] DIV4_LAST   = 2'h3;
  localparam logic [3:0] DIV16_LAST  = 4'hf;
  localparam logic [5:0] DIV64_LAST  = 6'h3f;

  typedef enum logic [1:0] {
    STMC_MODE_CMP  = 2'b00,
    STMC_MODE_CAP  = 2'b01,
    STMC_MODE_PWM  = 2'b10,
    STMC_MODE_TMR  = 2'b11
  } stmc_mode_t;

  typedef struct packed {
    logic       counter_pause;
    logic [2:0] count_clock_select;
    logic       run_enable;
  } stmc_ctrl0_t;

  typedef struct packed {
    stmc_mode_t operating_mode_field;
    logic [1:0] pin_function_field;
    logic       output_level_control;
    logic       output_invert;
    logic       duty_period_swap;
    logic       clear_source_select;
  } stmc_ctrl1_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0]        wdata;
    logic              wr;
    logic              rd;
  } stmc_bus_t;

  // one-step single-pulse sequencer, gray along idle-armed-active
  typedef enum logic [1:0] {
    STMC_SP_IDLE   = 2'b00,
    STMC_SP_ARMED  = 2'b01,
    STMC_SP_ACTIVE = 2'b11
  } stmc_sp_t;
endpackage

// *** design/stmc_edge_det.sv ***
// Purpose: synchroniser and edge detector for a pin input
// Assumes: pin is asynchronous to ref_clk
// Notes:   the second and third stages feed the edge logic
`timescale 1ns/1ps
module stmc_edge_det
  import stmc_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic ce,
  input  wire logic pin,
  output logic      rise,
  output logic      fall
);
  logic s1_q;
  logic s2_q;
  logic s3_q;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else if (ce) begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  assign rise = ce & s2_q & ~s3_q;
  assign fall = ce & ~s2_q & s3_q;
endmodule

// *** design/stmc_prescaler.sv ***
// Purpose: count-tick generator for the selectable clock sources
// Assumes: high and sub clocks arrive as enable strobes
// Notes:   ticks are one ref_clk cycle wide
`timescale 1ns/1ps
module stmc_prescaler
  import stmc_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       ce,
  input  wire logic       run,
  input  wire logic [2:0] sel,
  input  wire logic       high_clk_en,
  input  wire logic       sub_clk_en,
  input  wire logic       ext_rise,
  input  wire logic       ext_fall,
  output logic            tick
);
  logic [1:0] sys_div_q;
  logic [5:0] hi_div_q;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sys_div_q <= 2'h0;
    end else if (ce && run) begin
      sys_div_q <= sys_div_q + 2'h1;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      hi_div_q <= RST_PRE;
    end else if (ce && run && high_clk_en) begin
      hi_div_q <= hi_div_q + 6'h01;
    end
  end

  always_comb begin
    case (sel)
      CKS_SYS_D4: tick = sys_div_q == DIV4_LAST;
      CKS_SYS:    tick = 1'b1;
      CKS_HI_D16: tick = high_clk_en && hi_div_q[3:0] == DIV16_LAST;
      CKS_HI_D64: tick = high_clk_en && hi_div_q == DIV64_LAST;
      CKS_SUB0,
      CKS_SUB1:   tick = sub_clk_en;
      CKS_EXT_R:  tick = ext_rise;
      CKS_EXT_F:  tick = ext_fall;
      default:    tick = 1'b0;
    endcase
  end
endmodule

// *** design/stmc_core.sv ***
// Purpose: 16-bit standard timer with compare, capture and pwm modes
// Assumes: system clock is ref_clk; high and sub clocks as enable strobes
// Notes:   capture datapath and interrupt wiring are outside this block
`timescale 1ns/1ps
module stmc_core
  import stmc_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              rst,
  input  wire logic              ce,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [7:0]        wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output logic      [7:0]        rdata,
  input  wire logic              high_clk_en,
  input  wire logic              sub_clk_en,
  input  wire logic              external_count_clock_pin,
  input  wire logic              capture_input_pin,
  output logic                   timer_output_pin,
  output logic                   timer_output_pin_oe,
  output logic                   match_a_irq,
  output logic                   match_p_irq,
  output logic                   capture_event
);
  stmc_bus_t   bus;
  stmc_ctrl0_t c0_q;
  stmc_ctrl1_t c1_q;
  stmc_sp_t    sp_q;
  stmc_sp_t    sp_d;
  logic [15:0] cnt_q;
  logic [15:0] cmpa_q;
  logic [7:0]  period_q;
  logic [7:0]  hold_q;
  logic        run_prev_q;
  logic        level_q;
  logic        run_rise;
  logic        tick;
  logic        ext_rise;
  logic        ext_fall;
  logic        cap_rise;
  logic        cap_fall;
  logic        match_a;
  logic        match_p;
  logic        ovf;
  logic        clr;
  logic        cmp_like;
  logic        pwm_mode;
  logic        sp_active;
  logic        raw_out;

  assign bus = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

  function automatic logic is_wr(input stmc_bus_t b,
                                 input logic [ADDR_W-1:0] o);
    return b.wr && b.addr == o;
  endfunction

  function automatic logic is_rd(input stmc_bus_t b,
                                 input logic [ADDR_W-1:0] o);
    return b.rd && b.addr == o;
  endfunction

  stmc_edge_det u_ext_edge (
    .ref_clk (ref_clk),
    .rst     (rst),
    .ce      (ce),
    .pin     (external_count_clock_pin),
    .rise    (ext_rise),
    .fall    (ext_fall)
  );

  stmc_edge_det u_cap_edge (
    .ref_clk (ref_clk),
    .rst     (rst),
    .ce      (ce),
    .pin     (capture_input_pin),
    .rise    (cap_rise),
    .fall    (cap_fall)
  );

  stmc_prescaler u_pre (
    .ref_clk     (ref_clk),
    .rst         (rst),
    .ce          (ce),
    .run         (c0_q.run_enable),
    .sel         (c0_q.count_clock_select),
    .high_clk_en (high_clk_en),
    .sub_clk_en  (sub_clk_en),
    .ext_rise    (ext_rise),
    .ext_fall    (ext_fall),
    .tick        (tick)
  );

  // control registers; mode and pin field should change only when off
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      c0_q <= '0;
      c1_q <= '0;
    end else if (ce) begin
      if (is_wr(bus, OFS_CTRL0)) begin
        c0_q <= bus.wdata[7:3];
      end
      if (is_wr(bus, OFS_CTRL1)) begin
        c1_q <= bus.wdata;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      run_prev_q <= 1'b0;
    end else if (ce) begin
      run_prev_q <= c0_q.run_enable;
    end
  end

  assign run_rise = c0_q.run_enable & ~run_prev_q;
  assign pwm_mode = c1_q.operating_mode_field == STMC_MODE_PWM;
  assign cmp_like = c1_q.operating_mode_field == STMC_MODE_CMP ||
                    c1_q.operating_mode_field == STMC_MODE_TMR;

  // comparators qualified by the tick so each match is one pulse
  assign match_a = tick && cnt_q == cmpa_q;
  assign match_p = tick && period_q != PERIOD_OVF &&
                   cnt_q[15:8] == period_q &&
                   cnt_q[7:0] == RST_BYTE;
  assign ovf = tick && cnt_q == CNT_MAX;

  always_comb begin
    if (cmp_like) begin
      if (c1_q.clear_source_select) begin
        clr = match_a;
      end else begin
        clr = match_p || (period_q == PERIOD_OVF && ovf);
      end
    end else if (pwm_mode) begin
      if (c1_q.duty_period_swap) begin
        clr = match_a || ovf;
      end else begin
        clr = match_p || (period_q == PERIOD_OVF && ovf);
      end
    end else begin
      clr = ovf;
    end
  end

  // counter: no software write path; run rising or the clear condition clears it
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_q <= RST_WORD;
    end else if (ce) begin
      if (run_rise) begin
        cnt_q <= RST_WORD;
      end else if (c0_q.run_enable && !c0_q.counter_pause && tick) begin
        cnt_q <= clr ? RST_WORD : cnt_q + CNT_ONE;
      end
    end
  end

  // compare A pair and period; low byte staged in hold buffer
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cmpa_q   <= RST_WORD;
      period_q <= RST_BYTE;
      hold_q   <= RST_BYTE;
    end else if (ce) begin
      if (is_wr(bus, OFS_CMPA_LO)) begin
        hold_q <= bus.wdata;
      end else if (is_rd(bus, OFS_CNT_HI)) begin
        hold_q <= cnt_q[7:0];
      end else if (is_rd(bus, OFS_CMPA_HI)) begin
        hold_q <= cmpa_q[7:0];
      end
      if (is_wr(bus, OFS_CMPA_HI)) begin
        cmpa_q <= {bus.wdata, hold_q};
      end
      if (is_wr(bus, OFS_PERIOD)) begin
        period_q <= bus.wdata;
      end
    end
  end

  // single pulse: armed on run rise, fires on external edge
  always_comb begin
    sp_d = sp_q;
    case (sp_q)
      STMC_SP_IDLE: begin
        if (run_rise) begin
          sp_d = STMC_SP_ARMED;
        end
      end
      STMC_SP_ARMED: begin
        if (!c0_q.run_enable) begin
          sp_d = STMC_SP_IDLE;
        end else if (ext_rise) begin
          sp_d = STMC_SP_ACTIVE;
        end
      end
      STMC_SP_ACTIVE: begin
        if (!c0_q.run_enable || match_a) begin
          sp_d = STMC_SP_IDLE;
        end
      end
      default: sp_d = STMC_SP_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sp_q <= STMC_SP_IDLE;
    end else if (ce) begin
      sp_q <= sp_d;
    end
  end

  assign sp_active = sp_q == STMC_SP_ACTIVE;

  // compare-match level; held between matches
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      level_q <= 1'b0;
    end else if (ce) begin
      if (run_rise) begin
        level_q <= c1_q.output_level_control;
      end else if (c1_q.operating_mode_field == STMC_MODE_CMP &&
                   c0_q.run_enable && !c0_q.counter_pause && match_a) begin
        case (c1_q.pin_function_field)
          PF_00:   level_q <= level_q;
          PF_01:   level_q <= 1'b0;
          PF_10:   level_q <= 1'b1;
          PF_11:   level_q <= ~level_q;
          default: level_q <= level_q;
        endcase
      end
    end
  end

  // pwm: pin function 10 active while count below duty value; 00/01 forced, 11 single pulse
  always_comb begin
    raw_out = level_q;
    if (pwm_mode) begin
      case (c1_q.pin_function_field)
        PF_00: raw_out = ~c1_q.output_level_control;
        PF_01: raw_out = c1_q.output_level_control;
        PF_10: begin
          if (c1_q.duty_period_swap) begin
            raw_out = (cnt_q[15:8] < period_q) ~^
                      c1_q.output_level_control;
          end else begin
            raw_out = (cnt_q < cmpa_q) ~^ c1_q.output_level_control;
          end
          if (!c0_q.run_enable) begin
            raw_out = ~c1_q.output_level_control;
          end
        end
        PF_11: raw_out = sp_active ~^ c1_q.output_level_control;
        default: raw_out = level_q;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      timer_output_pin    <= 1'b0;
      timer_output_pin_oe <= 1'b0;
    end else if (ce) begin
      timer_output_pin    <= raw_out ^ c1_q.output_invert;
      timer_output_pin_oe <= c1_q.operating_mode_field == STMC_MODE_CMP ||
                             pwm_mode;
    end
  end

  // match pulses; p suppressed when compare A clears in cmp/timer
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      match_a_irq   <= 1'b0;
      match_p_irq   <= 1'b0;
      capture_event <= 1'b0;
    end else if (ce) begin
      match_a_irq <= c0_q.run_enable && !c0_q.counter_pause &&
                     match_a;
      match_p_irq <= c0_q.run_enable && !c0_q.counter_pause &&
                     (match_p || (period_q == PERIOD_OVF && ovf)) &&
                     !(cmp_like && c1_q.clear_source_select);
      if (c1_q.operating_mode_field == STMC_MODE_CAP &&
          c0_q.run_enable) begin
        case (c1_q.pin_function_field)
          PF_00:   capture_event <= cap_rise;
          PF_01:   capture_event <= cap_fall;
          PF_10:   capture_event <= cap_rise | cap_fall;
          default: capture_event <= 1'b0;
        endcase
      end else begin
        capture_event <= 1'b0;
      end
    end
  end

  // read data one cycle after strobe; unmapped reads zero
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rdata <= RST_BYTE;
    end else if (ce) begin
      rdata <= RST_BYTE;
      if (bus.rd) begin
        case (bus.addr)
          OFS_CTRL0:   rdata <= {c0_q, 3'b000} & CTRL0_MASK;
          OFS_CTRL1:   rdata <= c1_q;
          OFS_CNT_LO:  rdata <= hold_q;
          OFS_CNT_HI:  rdata <= cnt_q[15:8];
          OFS_CMPA_LO: rdata <= hold_q;
          OFS_CMPA_HI: rdata <= cmpa_q[15:8];
          OFS_PERIOD:  rdata <= period_q;
          default:     rdata <= RST_BYTE;
        endcase
      end
    end
  end
endmodule

// *** verif/stmc_core_checker.sv ***
// Purpose: concurrent checks on the timer core ports
// Assumes: control 0, control 1 and period writes mirrored in local shadow copies
// Notes:   settle windows cover the registered pin lag
`timescale 1ns/1ps
module stmc_core_checker
  import stmc_pkg::*;
(
  input wire logic              ref_clk,
  input wire logic              rst,
  input wire logic              ce,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [7:0]        wdata,
  input wire logic              wr,
  input wire logic              rd,
  input wire logic [7:0]        rdata,
  input wire logic              high_clk_en,
  input wire logic              sub_clk_en,
  input wire logic              external_count_clock_pin,
  input wire logic              capture_input_pin,
  input wire logic              timer_output_pin,
  input wire logic              timer_output_pin_oe,
  input wire logic              match_a_irq,
  input wire logic              match_p_irq,
  input wire logic              capture_event
);
  logic [7:0]  c0_q;
  logic [7:0]  c1_q;
  logic [7:0]  per_q;
  logic [2:0]  quiet_q;
  logic [16:0] gap_q;
  logic        clean_q;
  logic        p_cfg;
  logic        settled;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  assign settled = quiet_q == 3'h7;
  // gap only judged with sys clock, no pause, period clear, no writes
  assign p_cfg = c0_q[7:3] == 5'h03 && c1_q[6] == c1_q[7] && !c1_q[0]
                 && per_q != 8'h00 && ce && !wr;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      c0_q  <= 8'h00;
      c1_q  <= 8'h00;
      per_q <= 8'h00;
    end else if (ce && wr) begin
      if (addr == OFS_CTRL0) c0_q <= wdata;
      if (addr == OFS_CTRL1) c1_q <= wdata;
      if (addr == OFS_PERIOD) per_q <= wdata;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) quiet_q <= 3'h0;
    else if (wr) quiet_q <= 3'h0;
    else if (quiet_q != 3'h7) quiet_q <= quiet_q + 3'h1;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      gap_q   <= 17'h00000;
      clean_q <= 1'b0;
    end else begin
      gap_q   <= match_p_irq ? 17'h00001 : gap_q + 17'h00001;
      clean_q <= p_cfg && (clean_q || match_p_irq);
    end
  end

  sequence s_run_rise;
    wr && ce && addr == OFS_CTRL0 && wdata[3] && !c0_q[3];
  endsequence
  sequence s_cmp_mode;
    c1_q[7:6] == 2'b00;
  endsequence

  property p_run_init;
    s_run_rise ##0 s_cmp_mode |-> ##[1:3]
      timer_output_pin == (c1_q[3] ^ c1_q[2]);
  endproperty
  a_run_init: assert property (p_run_init)
    else $error("pin not at initial level after run rise");

  property p_ctrl0_read;
    rd && ce && addr == OFS_CTRL0 |=> rdata == (c0_q & CTRL0_MASK);
  endproperty
  a_ctrl0_read: assert property (p_ctrl0_read)
    else $error("control 0 read value wrong");

  property p_period_gap;
    match_p_irq && clean_q |-> gap_q >= {1'b0, per_q, 8'h00}
      && gap_q <= {1'b0, per_q, 8'h01};
  endproperty
  a_period_gap: assert property (p_period_gap)
    else $error("period match spacing wrong");

  property p_cmp_level;
    match_a_irq && c1_q[7:6] == 2'b00 && c1_q[5] != c1_q[4] && settled
      |-> ##[0:2] timer_output_pin == (c1_q[5] ^ c1_q[2]);
  endproperty
  a_cmp_level: assert property (p_cmp_level)
    else $error("compare match level wrong");

  property p_pwm_forced;
    c1_q[7:6] == 2'b10 && !c1_q[5] && c0_q[3] && settled
      |-> timer_output_pin == (~(c1_q[4] ^ c1_q[3]) ^ c1_q[2]);
  endproperty
  a_pwm_forced: assert property (p_pwm_forced)
    else $error("forced pwm level wrong");

  property p_tmr_oe;
    c1_q[7:6] == 2'b11 && settled |-> !timer_output_pin_oe;
  endproperty
  a_tmr_oe: assert property (p_tmr_oe)
    else $error("pin driven in timer mode");

  property p_cap_off;
    c1_q[7:4] == 4'h7 && settled |-> !capture_event;
  endproperty
  a_cap_off: assert property (p_cap_off)
    else $error("capture while disabled");

  property p_cap_rise;
    $rose(capture_input_pin) && c1_q[7:4] == 4'h4 && c0_q[3] && settled
      |-> ##[1:5] capture_event;
  endproperty
  a_cap_rise: assert property (p_cap_rise)
    else $error("rising capture missed");

  property p_irq_pulse;
    match_p_irq |=> !match_p_irq;
  endproperty
  a_irq_pulse: assert property (p_irq_pulse)
    else $error("period match pulse too long");
endmodule

bind stmc_core stmc_core_checker u_stmc_core_checker (
  .ref_clk, .rst, .ce, .addr, .wdata, .wr, .rd, .rdata, .high_clk_en,
  .sub_clk_en, .external_count_clock_pin, .capture_input_pin,
  .timer_output_pin, .timer_output_pin_oe, .match_a_irq, .match_p_irq,
  .capture_event
);

// *** verif/tb_stmc_core.sv ***
// Purpose: self-checking bench for the standard timer core
// Assumes: high and sub clocks modelled as enable strobes
// Notes:   count windows allow a few cycles of sync lag
`timescale 1ns/1ps
module tb_stmc_core
  import stmc_pkg::*;
;
  logic              ref_clk = 1'b0;
  logic              rst, ce, wr, rd;
  logic [ADDR_W-1:0] addr;
  logic [7:0]        wdata, rdata, d;
  logic              high_clk_en, sub_clk_en, external_count_clock_pin;
  logic              capture_input_pin, timer_output_pin;
  logic              timer_output_pin_oe, match_a_irq, match_p_irq;
  logic              capture_event;
  logic [3:0]        fcnt = 4'h0;
  logic [15:0]       v, w;
  int                errors, cmp_count, n, h, e;
  logic [18:0]       rows [6] = '{{OFS_CTRL1, 8'ha5, 8'ha5},
    {OFS_PERIOD, 8'h3c, 8'h3c}, {OFS_CTRL0, 8'hf7, 8'hf0},
    {3'h7, 8'hff, 8'h00}, {OFS_CMPA_HI, 8'h5a, 8'h5a},
    {OFS_CNT_HI, 8'hff, 8'h00}};
  int                ck_exp [8] = '{64, 256, 8, 2, 32, 32, 16, 16};
  int                cm_exp [4] = '{0, 1, 0, 1};
  int                cap_exp [4] = '{1, 1, 2, 0};

  stmc_core u_stmc_core (
    .ref_clk, .rst, .ce, .addr, .wdata, .wr, .rd, .rdata, .high_clk_en,
    .sub_clk_en, .external_count_clock_pin, .capture_input_pin,
    .timer_output_pin, .timer_output_pin_oe, .match_a_irq, .match_p_irq,
    .capture_event
  );

  always #20 ref_clk = ~ref_clk;

  // strobes unrelated to the register traffic
  always @(posedge ref_clk) begin
    fcnt                     <= fcnt + 4'h1;
    high_clk_en              <= fcnt[0];
    sub_clk_en               <= fcnt[2:0] == 3'h7;
    external_count_clock_pin <= fcnt[3];
  end

  task automatic check(input string nm, input logic [15:0] x,
                       input logic [15:0] g);
    cmp_count++;
    if (g !== x) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, x, g);
    end
  endtask

  task automatic wreg(input logic [2:0] a, input logic [7:0] dv);
    @(posedge ref_clk);
    addr  <= a;
    wdata <= dv;
    wr    <= 1'b1;
    @(posedge ref_clk);
    wr    <= 1'b0;
  endtask

  task automatic rreg(input logic [2:0] a, output logic [7:0] dv);
    @(posedge ref_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge ref_clk);
    rd   <= 1'b0;
    #1;
    dv = rdata;
  endtask

  // high read first so the low byte comes from the same snapshot
  task automatic rcnt(output logic [15:0] c);
    rreg(OFS_CNT_HI, c[15:8]);
    rreg(OFS_CNT_LO, c[7:0]);
  endtask

  // always switch off before touching the mode or pin fields
  task automatic setup(input logic [7:0] c1, input logic [7:0] c0);
    wreg(OFS_CTRL0, c0 & 8'hf7);
    wreg(OFS_CTRL1, c1);
    wreg(OFS_CTRL0, c0);
  endtask

  // cycles until a match pulse, counting high pin cycles on the way
  task automatic wait_irq(input logic use_a, output int c, output int hi);
    c  = 0;
    hi = 0;
    do begin
      @(posedge ref_clk);
      #1;
      c++;
      hi += int'(timer_output_pin === 1'b1);
    end while ((use_a ? match_a_irq : match_p_irq) !== 1'b1 && c < 2000);
    check("match pulse seen", 16'h1, 16'(c < 2000));
  endtask

  task automatic summarize;
    $display("compares %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk);
    errors++;
    summarize;
  end

  initial begin
    {rst, ce, wr, rd, addr, wdata, capture_input_pin} = {4'b1100, 12'h0};
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    for (int a = 0; a < 7; a++) begin
      rreg(3'(a), d);
      check("reset value", 16'h0, 16'(d));
    end
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      wreg(rows[i][18:16], rows[i][15:8]);
      rreg(rows[i][18:16], d);
      check("register row", 16'(rows[i][7:0]), 16'(d));
    end
    wreg(OFS_CMPA_LO, 8'h34);
    wreg(OFS_CMPA_HI, 8'h12);
    rreg(OFS_CMPA_HI, v[15:8]);
    rreg(OFS_CMPA_LO, v[7:0]);
    check("compare a pair", 16'h1234, v);
    $display("test registers done");
    wreg(OFS_PERIOD, 8'h00);
    for (int i = 0; i < 8; i++) begin
      setup(8'h00, {1'b0, 3'(i), 4'h8});
      repeat (256) @(posedge ref_clk);
      wreg(OFS_CTRL0, {1'b0, 3'(i), 4'h0});
      rcnt(v);
      e = ck_exp[i];
      check("clock select", 16'h1, 16'(v >= e - e / 16 - 2 &&
            v <= e + e / 16 + 2));
    end
    $display("test clock select done");
    wreg(OFS_PERIOD, 8'h01);
    setup(8'h00, 8'h18);
    wait_irq(1'b0, n, h);
    wait_irq(1'b0, n, h);
    check("period gap", 16'h1, 16'(n == 256 || n == 257));
    wreg(OFS_CTRL0, 8'h98);
    rcnt(v);
    repeat (20) @(posedge ref_clk);
    rcnt(w);
    check("paused count", v, w);
    wreg(OFS_CTRL0, 8'h18);
    repeat (20) @(posedge ref_clk);
    rcnt(v);
    check("resumed count", 16'h1, 16'(v > w));
    wreg(OFS_CTRL0, 8'h10);
    rcnt(v);
    repeat (20) @(posedge ref_clk);
    rcnt(w);
    check("held count", v, w);
    wreg(OFS_CTRL0, 8'h18);
    rcnt(v);
    check("cleared count", 16'h1, 16'(v < 16'h0010));
    $display("test counter done");
    wreg(OFS_CMPA_LO, 8'h10);
    wreg(OFS_CMPA_HI, 8'h00);
    for (int p = 0; p < 4; p++) begin
      setup({2'b00, 2'(p), 4'hd}, 8'h18);
      repeat (4) @(posedge ref_clk);
      check("initial pin", 16'h0, 16'(timer_output_pin));
      wait_irq(1'b1, n, h);
      repeat (3) @(posedge ref_clk);
      check("match pin", 16'(cm_exp[p]), 16'(timer_output_pin));
    end
    for (int p = 0; p < 2; p++) begin
      setup({2'b10, 2'(p), 4'h8}, 8'h18);
      repeat (10) @(posedge ref_clk);
      check("forced pwm", 16'(p), 16'(timer_output_pin));
    end
    wreg(OFS_CMPA_LO, 8'h40);
    wreg(OFS_CMPA_HI, 8'h00);
    setup(8'ha8, 8'h18);
    wait_irq(1'b0, n, h);
    wait_irq(1'b0, n, h);
    check("pwm duty", 16'h1, 16'(h >= 62 && h <= 66));
    wreg(OFS_CMPA_LO, 8'h00);
    wreg(OFS_CMPA_HI, 8'h02);
    setup(8'haa, 8'h18);
    wait_irq(1'b1, n, h);
    wait_irq(1'b1, n, h);
    check("swapped duty", 16'h1, 16'(h >= 254 && h <= 258));
    check("swapped period", 16'h1, 16'(n >= 512 && n <= 514));
    wreg(OFS_CMPA_LO, 8'h80);
    wreg(OFS_CMPA_HI, 8'h00);
    setup(8'hb8, 8'h18);
    wait_irq(1'b1, n, h);
    check("pulse width", 16'h1, 16'(h >= 100 && h <= 130));
    repeat (3) @(posedge ref_clk);
    check("pulse end", 16'h0, 16'(timer_output_pin));
    setup(8'hc0, 8'h18);
    repeat (10) @(posedge ref_clk);
    check("timer mode drive", 16'h0, 16'(timer_output_pin_oe));
    $display("test output done");
    for (int p = 0; p < 4; p++) begin
      setup({2'b01, 2'(p), 4'h0}, 8'h18);
      n = 0;
      for (int k = 0; k < 40; k++) begin
        @(posedge ref_clk);
        if (k == 12) capture_input_pin <= 1'b1;
        if (k == 26) capture_input_pin <= 1'b0;
        #1;
        n += int'(capture_event === 1'b1);
      end
      check("capture count", 16'(cap_exp[p]), 16'(n));
    end
    $display("test capture done");
    setup(8'h08, 8'h18);
    repeat (4) @(posedge ref_clk);
    check("oe before reset", 16'h1, 16'(timer_output_pin_oe));
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    #1;
    check("reset drive", 16'h0, 16'(timer_output_pin_oe));
    @(posedge ref_clk);
    rst <= 1'b0;
    rreg(OFS_CTRL1, d);
    check("second reset", 16'h0, 16'(d));
    $display("test second reset done");
    summarize;
  end
endmodule
